// file: common/gar_pkg.sv
// gas alarm relay controller: shared constants, types and structs
// assumes a 50 MHz system clock; readings are in tenths of a percent
package gar_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint GAR_CLK_HZ      = 50_000_000;
    localparam longint GAR_MENU_HOLD_S = 6;
    localparam longint GAR_INHIBIT_S   = 60;
    localparam longint GAR_IDLE_S      = 300;
    localparam longint GAR_RPT_SLOW_S  = 60;
    localparam longint GAR_RPT_FAST_S  = 5;
    localparam longint GAR_HOLD_CYC    = GAR_MENU_HOLD_S * GAR_CLK_HZ;
    localparam longint GAR_INHIBIT_CYC = GAR_INHIBIT_S * GAR_CLK_HZ;
    localparam longint GAR_IDLE_CYC    = GAR_IDLE_S * GAR_CLK_HZ;
    localparam longint GAR_SLOW_CYC    = GAR_RPT_SLOW_S * GAR_CLK_HZ;
    localparam longint GAR_FAST_CYC    = GAR_RPT_FAST_S * GAR_CLK_HZ;

    typedef logic [35:0] gar_tick_type;
    typedef logic [15:0] gar_rdg_type;

    // ----------------------------------------------------------------
    // thresholds (non-oxygen in whole percent, oxygen in tenths)
    // ----------------------------------------------------------------
    localparam gar_rdg_type GAR_BG_DEF    = 16'h0004;
    localparam gar_rdg_type GAR_BG_MIN    = 16'h0001;
    localparam gar_rdg_type GAR_BG_MAX    = 16'h000A;
    localparam gar_rdg_type GAR_PCT_SCALE = 16'h000A;
    localparam gar_rdg_type GAR_O2_LO_DEF = 16'h00BE;
    localparam gar_rdg_type GAR_O2_HI_DEF = 16'h00DC;
    localparam gar_rdg_type GAR_O2_MIN    = 16'h006E;
    localparam gar_rdg_type GAR_O2_MAX    = 16'h00F0;
    localparam logic [19:0] GAR_HYST_NUM  = 20'h00009;
    localparam logic [19:0] GAR_HYST_DEN  = 20'h0000A;
    localparam logic [1:0]  GAR_LATCH_DEF = 2'h0;
    localparam logic [1:0]  GAR_FS_DEF    = 2'h0;
    localparam logic [15:0] GAR_CNT_MAX   = 16'hFFFF;

    // ----------------------------------------------------------------
    // menu screens
    // ----------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_NORMAL  = 9'h001,
        ST_TIMERS  = 9'h002,
        ST_UNIT    = 9'h004,
        ST_BG_LO   = 9'h008,
        ST_BG_HI   = 9'h010,
        ST_R1_MODE = 9'h020,
        ST_R2_MODE = 9'h040,
        ST_R1_FS   = 9'h080,
        ST_R2_FS   = 9'h100
    } gar_state_type;

    typedef struct packed {
        logic page;
        logic raise;
        logic lower;
    } gar_keys_type;

    typedef struct packed {
        gar_rdg_type bg;
        gar_rdg_type o2_lo;
        gar_rdg_type o2_hi;
        logic [1:0]  latch;
        logic [1:0]  failsafe;
    } gar_cfg_type;

    typedef struct packed {
        logic [15:0] days_zero;
        logic [15:0] days_cal;
        logic [15:0] cal_num;
        logic [15:0] radio_miss;
        logic [31:0] mfg_date;
        logic [31:0] serial;
    } gar_info_type;

endpackage

// file: hdl/gar_top.sv
// gas alarm relay controller: menu, report rate, relays, info counters
// assumes all inputs synchronous to clk; key inputs are raw levels
`timescale 1ns/1ps

// Behaviour
// RQ1 - hold page six seconds to open menu
// RQ2 - timed span refreshes cal; keyed needs press
// RQ3 - count days since zero, cal, cal number
// RQ4 - count missed radio reports, show date, serial
// RQ5 - report each minute, five seconds above background
// RQ6 - background default 4, range 1 to 10
// RQ7 - oxygen low/high thresholds, 11.0 to 24.0
// RQ8 - per-relay latching or auto, auto default
// RQ9 - auto release ten percent below set-point
// RQ10 - latched until manual reset below set-point
// RQ11 - no alarm one minute after menu exit
// RQ12 - fail-safe inverts relay, off when unit off
// RQ13 - fail-safe defaults off
// RQ14 - raise/lower toggle mode, page commits, advances
// RQ15 - five idle minutes return to normal
// RQ16 - drive equals alarm xor fail-safe, gated
module gar_top
#(
    parameter gar_pkg::gar_tick_type HOLD_CYC    = gar_pkg::gar_tick_type'(gar_pkg::GAR_HOLD_CYC),
    parameter gar_pkg::gar_tick_type INHIBIT_CYC = gar_pkg::gar_tick_type'(gar_pkg::GAR_INHIBIT_CYC),
    parameter gar_pkg::gar_tick_type IDLE_CYC    = gar_pkg::gar_tick_type'(gar_pkg::GAR_IDLE_CYC),
    parameter gar_pkg::gar_tick_type SLOW_CYC    = gar_pkg::gar_tick_type'(gar_pkg::GAR_SLOW_CYC),
    parameter gar_pkg::gar_tick_type FAST_CYC    = gar_pkg::gar_tick_type'(gar_pkg::GAR_FAST_CYC),
    parameter logic [31:0]           MFG_DATE    = 32'h0000_0000, // arbitrary value
    parameter logic [31:0]           SERIAL_NUM  = 32'h0000_0000  // arbitrary value
)
(
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   sys_rst,
    // keys
    input  wire gar_pkg::gar_keys_type  keys,
    input  wire logic                   relay_reset_key,
    // sensor and unit state
    input  wire logic                   unit_on,
    input  wire logic                   o2_sensor,
    input  wire gar_pkg::gar_rdg_type   gas_reading,
    input  wire gar_pkg::gar_rdg_type [1:0] alarm_setpoint,
    // calibration and radio events
    input  wire logic                   span_timed_done,
    input  wire logic                   span_keyed_active,
    input  wire logic                   span_keyed_done,
    input  wire logic                   zero_done,
    input  wire logic                   day_tick,
    input  wire logic                   radio_missed,
    // status and outputs
    output gar_pkg::gar_state_type      menu_screen,
    output logic                        alarm_inhibit,
    output logic                        report_tick,
    output logic                        fast_rate,
    output logic [1:0]                  relay_alarm,
    output logic [1:0]                  relay_drive,
    output gar_pkg::gar_cfg_type        cfg,
    output gar_pkg::gar_info_type       info
);
    import gar_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic gar_rdg_type step_val(gar_rdg_type v, logic up, gar_rdg_type lo, gar_rdg_type hi);
        if (up)
            step_val = (v >= hi) ? v : v + 16'h0001;
        else
            step_val = (v <= lo) ? v : v - 16'h0001;
    endfunction

    function automatic logic [15:0] sat_inc(logic [15:0] v);
        sat_inc = (v == GAR_CNT_MAX) ? v : v + 16'h0001;
    endfunction

    function automatic logic hyst_clear(gar_rdg_type rd, gar_rdg_type sp);
        hyst_clear = (20'(rd) * GAR_HYST_DEN) <= (20'(sp) * GAR_HYST_NUM);
    endfunction

    // ----------------------------------------------------------------
    // key edges
    // ----------------------------------------------------------------
    gar_keys_type  keys_q_r;
    gar_state_type state_r;
    gar_state_type state_nxt;
    gar_tick_type  hold_cnt_r;
    gar_tick_type  idle_cnt_r;
    gar_tick_type  inhibit_cnt_r;
    gar_tick_type  rpt_cnt_r;
    gar_rdg_type   bg_r;
    gar_rdg_type   o2_lo_r;
    gar_rdg_type   o2_hi_r;
    logic [1:0]    latch_r;
    logic [1:0]    pend_r;
    logic [1:0]    failsafe_r;
    logic [1:0]    alarm_r;
    logic [1:0]    drive_r;
    logic          report_r;
    logic          fast_r;
    logic          span_touched_r;
    logic [15:0]   days_zero_r;
    logic [15:0]   days_cal_r;
    logic [15:0]   cal_num_r;
    logic [15:0]   miss_r;
    logic          page_ev;
    logic          adj_ev;
    logic          up_ev;
    logic          any_ev;
    logic          in_menu;
    logic          menu_enter;
    logic          idle_out;
    logic          blocked;
    logic          fast_nxt;
    logic          cal_refresh;

    // edge detect of key presses
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            keys_q_r <= '0;
        else
            keys_q_r <= keys;
    end

    assign page_ev = keys.page & ~keys_q_r.page;
    assign up_ev   = keys.raise & ~keys_q_r.raise;
    assign adj_ev  = up_ev | (keys.lower & ~keys_q_r.lower);
    assign any_ev  = page_ev | adj_ev;
    assign in_menu = (state_r != ST_NORMAL);

    // ----------------------------------------------------------------
    // menu navigation
    // ----------------------------------------------------------------
    // long page hold while in normal operation
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            hold_cnt_r <= '0;
        else if (!in_menu && keys.page && hold_cnt_r != HOLD_CYC - 36'h1)
            hold_cnt_r <= hold_cnt_r + 36'h1;
        else if (in_menu || !keys.page)
            hold_cnt_r <= '0;
    end

    assign menu_enter = !in_menu && keys.page && (hold_cnt_r == HOLD_CYC - 36'h1); // RQ1
    assign idle_out   = in_menu && !any_ev && (idle_cnt_r == IDLE_CYC - 36'h1);  // RQ15

    // inactivity timer, restarted by any page, raise or lower key press
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            idle_cnt_r <= '0;
        else if (!in_menu || any_ev)
            idle_cnt_r <= '0;
        else
            idle_cnt_r <= idle_cnt_r + 36'h1; // RQ15
    end

    // screen sequence
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_NORMAL:  if (menu_enter) state_nxt = ST_TIMERS; // RQ1
            ST_TIMERS:  if (page_ev) state_nxt = ST_UNIT;
            ST_UNIT:    if (page_ev) state_nxt = ST_BG_LO;
            ST_BG_LO:   if (page_ev) state_nxt = o2_sensor ? ST_BG_HI : ST_R1_MODE;
            ST_BG_HI:   if (page_ev) state_nxt = ST_R1_MODE;
            ST_R1_MODE: if (page_ev) state_nxt = ST_R2_MODE; // RQ14
            ST_R2_MODE: if (page_ev) state_nxt = ST_R1_FS;   // RQ14
            ST_R1_FS:   if (page_ev) state_nxt = ST_R2_FS;
            ST_R2_FS:   if (page_ev) state_nxt = ST_NORMAL;
            default:    state_nxt = ST_NORMAL;
        endcase
        if (idle_out)
            state_nxt = ST_NORMAL; // RQ15
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            state_r <= ST_NORMAL;
        else
            state_r <= state_nxt;
    end

    // alarm inhibit after leaving the menu
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            inhibit_cnt_r <= '0;
        else if (in_menu && state_nxt == ST_NORMAL)
            inhibit_cnt_r <= INHIBIT_CYC; // RQ11
        else if (inhibit_cnt_r != '0)
            inhibit_cnt_r <= inhibit_cnt_r - 36'h1;
    end

    assign blocked = in_menu || (inhibit_cnt_r != '0); // RQ11

    // ----------------------------------------------------------------
    // settings
    // ----------------------------------------------------------------
    // background and oxygen thresholds
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bg_r    <= GAR_BG_DEF;    // RQ6
            o2_lo_r <= GAR_O2_LO_DEF; // RQ7
            o2_hi_r <= GAR_O2_HI_DEF; // RQ7
        end
        else if (adj_ev && state_r == ST_BG_LO && !o2_sensor)
            bg_r <= step_val(bg_r, up_ev, GAR_BG_MIN, GAR_BG_MAX); // RQ6
        else if (adj_ev && state_r == ST_BG_LO)
            o2_lo_r <= step_val(o2_lo_r, up_ev, GAR_O2_MIN, GAR_O2_MAX); // RQ7
        else if (adj_ev && state_r == ST_BG_HI)
            o2_hi_r <= step_val(o2_hi_r, up_ev, GAR_O2_MIN, GAR_O2_MAX); // RQ7
    end

    // relay mode with pending choice, and fail-safe selection
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            latch_r    <= GAR_LATCH_DEF; // RQ8
            pend_r     <= GAR_LATCH_DEF;
            failsafe_r <= GAR_FS_DEF;    // RQ13
        end
        else
        begin
            if (menu_enter)
                pend_r <= latch_r;
            else if (adj_ev && state_r == ST_R1_MODE)
                pend_r[0] <= ~pend_r[0]; // RQ14
            else if (adj_ev && state_r == ST_R2_MODE)
                pend_r[1] <= ~pend_r[1]; // RQ14
            if (page_ev && state_r == ST_R1_MODE)
                latch_r[0] <= pend_r[0]; // RQ14
            if (page_ev && state_r == ST_R2_MODE)
                latch_r[1] <= pend_r[1]; // RQ14
            if (adj_ev && state_r == ST_R1_FS)
                failsafe_r[0] <= ~failsafe_r[0];
            if (adj_ev && state_r == ST_R2_FS)
                failsafe_r[1] <= ~failsafe_r[1];
        end
    end

    // ----------------------------------------------------------------
    // radio report rate
    // ----------------------------------------------------------------
    assign fast_nxt = o2_sensor ? (gas_reading <= o2_lo_r || gas_reading >= o2_hi_r)
                                : (gas_reading >= bg_r * GAR_PCT_SCALE); // RQ5

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rpt_cnt_r <= SLOW_CYC - 36'h1;
            report_r  <= 1'b0;
            fast_r    <= 1'b0;
        end
        else
        begin
            fast_r   <= fast_nxt;
            report_r <= (rpt_cnt_r == '0);
            if (rpt_cnt_r == '0)
                rpt_cnt_r <= (fast_nxt ? FAST_CYC : SLOW_CYC) - 36'h1; // RQ5
            else if (fast_nxt && rpt_cnt_r > FAST_CYC - 36'h1)
                rpt_cnt_r <= FAST_CYC - 36'h1; // RQ5
            else
                rpt_cnt_r <= rpt_cnt_r - 36'h1;
        end
    end

    // ----------------------------------------------------------------
    // alarm relays
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            alarm_r <= '0;
        else
            for (int i = 0; i < 2; i++)
            begin
                if (!alarm_r[i])
                    alarm_r[i] <= (gas_reading >= alarm_setpoint[i]) && !blocked; // RQ11
                else if (latch_r[i])
                    alarm_r[i] <= !(relay_reset_key && gas_reading < alarm_setpoint[i]); // RQ10
                else
                    alarm_r[i] <= !hyst_clear(gas_reading, alarm_setpoint[i]); // RQ9
            end
    end

    // output polarity
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            drive_r <= '0;
        else
            drive_r <= unit_on ? (alarm_r ^ failsafe_r) : 2'h0; // RQ12 RQ16
    end

    // ----------------------------------------------------------------
    // zero, calibration and radio information
    // ----------------------------------------------------------------
    assign cal_refresh = span_timed_done || (span_keyed_done && (span_touched_r || (adj_ev && span_keyed_active)));

    // keyed span touched by at least one adjustment
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            span_touched_r <= 1'b0;
        else if (adj_ev && span_keyed_active)
            span_touched_r <= 1'b1; // RQ2
        else if (span_keyed_done || !span_keyed_active)
            span_touched_r <= 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            days_zero_r <= '0;
            days_cal_r  <= '0;
            cal_num_r   <= '0;
        end
        else
        begin
            if (zero_done)
                days_zero_r <= '0; // RQ3
            else if (day_tick)
                days_zero_r <= sat_inc(days_zero_r); // RQ3
            if (cal_refresh)
            begin
                days_cal_r <= '0;                   // RQ2
                cal_num_r  <= sat_inc(cal_num_r);   // RQ3
            end
            else if (day_tick)
                days_cal_r <= sat_inc(days_cal_r);  // RQ3
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            miss_r <= '0;
        else if (radio_missed)
            miss_r <= sat_inc(miss_r); // RQ4
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign menu_screen   = state_r;
    assign alarm_inhibit = blocked;
    assign report_tick   = report_r;
    assign fast_rate     = fast_r;
    assign relay_alarm   = alarm_r;
    assign relay_drive   = drive_r;
    assign cfg           = '{bg: bg_r, o2_lo: o2_lo_r, o2_hi: o2_hi_r, latch: latch_r, failsafe: failsafe_r};
    assign info          = '{days_zero: days_zero_r, days_cal: days_cal_r, cal_num: cal_num_r,
                             radio_miss: miss_r, mfg_date: MFG_DATE, serial: SERIAL_NUM};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_MENU_ENTRY: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
        $rose(state_r == ST_TIMERS) |-> $past(keys.page) && $past(hold_cnt_r) == HOLD_CYC - 36'h1)
        else $error("menu opened without full page hold");
    AST_IDLE_EXIT: assert property (@(posedge clk) disable iff (sys_rst) // RQ15
        idle_out |=> state_r == ST_NORMAL && inhibit_cnt_r == INHIBIT_CYC)
        else $error("idle timeout did not return to normal");
    AST_INHIBIT: assert property (@(posedge clk) disable iff (sys_rst) // RQ11
        blocked && alarm_r == 2'h0 |=> alarm_r == 2'h0)
        else $error("alarm raised during inhibit");
    AST_AUTO_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
        alarm_r[1] && !latch_r[1] && !hyst_clear(gas_reading, alarm_setpoint[1]) |=> alarm_r[1])
        else $error("auto relay released inside hysteresis");
    AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // RQ10
        alarm_r[0] && latch_r[0] && !(relay_reset_key && gas_reading < alarm_setpoint[0]) |=> alarm_r[0])
        else $error("latched relay released without valid reset");
    AST_DRIVE: assert property (@(posedge clk) disable iff (sys_rst) // RQ12 RQ16
        ##1 relay_drive == ($past(unit_on) ? ($past(alarm_r) ^ $past(failsafe_r)) : 2'h0))
        else $error("relay drive polarity wrong");
    AST_RATE: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        rpt_cnt_r == '0 |=> rpt_cnt_r == ($past(fast_nxt) ? FAST_CYC : SLOW_CYC) - 36'h1 ##0 report_tick)
        else $error("report period reload wrong");
    AST_BG_RANGE: assert property (@(posedge clk) disable iff (sys_rst) // RQ6 RQ7
        bg_r >= GAR_BG_MIN && bg_r <= GAR_BG_MAX && o2_lo_r >= GAR_O2_MIN && o2_hi_r <= GAR_O2_MAX)
        else $error("threshold out of range");
    AST_CAL_KEYED: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        span_keyed_done && !span_timed_done && !span_touched_r && !adj_ev |=> $stable(cal_num_r))
        else $error("untouched keyed span refreshed calibration");
    AST_MODE_COMMIT: assert property (@(posedge clk) disable iff (sys_rst) // RQ14
        page_ev && state_r == ST_R1_MODE |=> latch_r[0] == $past(pend_r[0]) && state_r == ST_R2_MODE)
        else $error("relay mode not committed on page");
    AST_MISS: assert property (@(posedge clk) disable iff (sys_rst) // RQ4
        radio_missed && miss_r != GAR_CNT_MAX |=> miss_r == $past(miss_r) + 16'h0001)
        else $error("missed radio count not advanced");

    COV_MENU: cover property (@(posedge clk) disable iff (sys_rst) state_r == ST_R2_FS ##1 state_r == ST_NORMAL);
    COV_LATCH: cover property (@(posedge clk) disable iff (sys_rst) latch_r[0] && $fell(alarm_r[0]));
    COV_FAST: cover property (@(posedge clk) disable iff (sys_rst) report_tick && fast_rate);
    COV_FS: cover property (@(posedge clk) disable iff (sys_rst) failsafe_r[0] && unit_on && relay_drive[0]);

endmodule // gar_top

// file: tb/gar_ctrl_model.sv
// remote controller model: counts radio reports and the gap between them
// assumes report_tick is a one-cycle pulse synchronous to clk
`timescale 1ns/1ps
module gar_ctrl_model
(
    // clock
    input  wire logic clk,
    // report pulses from the detector
    input  wire logic report_tick,
    // what the controller has seen
    output int        rpt_count,
    output int        rpt_gap
);
    int since;
    // count cycles between received reports
    initial
    begin
        rpt_count = 0;
        rpt_gap   = 0;
        since     = 0;
    end
    always @(posedge clk)
    begin
        since = since + 1;
        if (report_tick)
        begin
            rpt_gap   <= since;
            rpt_count <= rpt_count + 1;
            since = 0;
        end
    end
endmodule // gar_ctrl_model

// file: tb/tb_top.sv
// testbench: keys, readings and events in; menu, reports, relays, counters out
// assumes gar_pkg and gar_top compiled first; short timing parameters
`timescale 1ns/1ps
module tb_top;
    import gar_pkg::*;
    localparam int HOLD = 20, INH = 40, IDLE = 60, SLOW = 50, FAST = 10;
    logic              clk, sys_rst, relay_reset_key, unit_on, o2_sensor, span_timed_done;
    logic              span_keyed_active, span_keyed_done, zero_done, day_tick, radio_missed;
    gar_keys_type      keys;
    gar_rdg_type       gas;
    gar_rdg_type [1:0] sp;
    gar_state_type     menu_screen;
    logic              alarm_inhibit, report_tick, fast_rate;
    logic [1:0]        relay_alarm, relay_drive;
    gar_cfg_type       cfg;
    gar_info_type      info;
    int                num_errors = 0, num_checks = 0, cycles = 0, seed = 68, rpt_count, rpt_gap, n;

    gar_top #(.HOLD_CYC(HOLD), .INHIBIT_CYC(INH), .IDLE_CYC(IDLE), .SLOW_CYC(SLOW), .FAST_CYC(FAST),
              .MFG_DATE(32'h0000_0A5A), .SERIAL_NUM(32'h0000_5A5A)) i_dut
    (
        .clk(clk), .sys_rst(sys_rst), .keys(keys), .relay_reset_key(relay_reset_key), .unit_on(unit_on),
        .o2_sensor(o2_sensor), .gas_reading(gas), .alarm_setpoint(sp), .span_timed_done(span_timed_done),
        .span_keyed_active(span_keyed_active), .span_keyed_done(span_keyed_done), .zero_done(zero_done),
        .day_tick(day_tick), .radio_missed(radio_missed), .menu_screen(menu_screen),
        .alarm_inhibit(alarm_inhibit), .report_tick(report_tick), .fast_rate(fast_rate),
        .relay_alarm(relay_alarm), .relay_drive(relay_drive), .cfg(cfg), .info(info)
    );
    gar_ctrl_model i_ctrl (.clk(clk), .report_tick(report_tick), .rpt_count(rpt_count), .rpt_gap(rpt_gap));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic press(input int which); // 2 page, 1 raise, 0 lower
        keys[which] = 1'b1;
        cyc(1);
        keys = '0;
        cyc(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(1);
    endtask
    task automatic enter;
        keys.page = 1'b1;
        cyc(HOLD + 1);
        keys = '0;
        cyc(1);
    endtask
    task automatic wait_rpt;
        n = rpt_count;
        for (int i = 0; i < 200 && rpt_count == n; i++) @(negedge clk);
        chk(rpt_count != n, 1'b1, "report seen");
    endtask
    function automatic logic exp_fast(input gar_rdg_type rd, input gar_rdg_type bg);
        return rd >= bg * 16'h000A;
    endfunction
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // clock and hang limit
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {sys_rst, unit_on} = 2'h3;
        {relay_reset_key, o2_sensor, span_timed_done, span_keyed_active} = 4'h0;
        {span_keyed_done, zero_done, day_tick, radio_missed} = 4'h0;
        keys = '0;
        gas = '0;
        sp = {16'h01F4, 16'h01F4};
        repeat (20) @(posedge clk);
        @(negedge clk) sys_rst = 1'b0;
        chk(cfg.bg, 16'h0004, "bg default");
        chk({cfg.o2_lo, cfg.o2_hi}, {16'h00BE, 16'h00DC}, "o2 defaults");
        chk({cfg.latch, cfg.failsafe}, 4'h0, "relay defaults");
        // report rate slow, random readings, then fast at boundary
        wait_rpt();
        wait_rpt();
        chk(rpt_gap, SLOW, "slow gap");
        repeat (8)
        begin
            gas = gar_rdg_type'({$random(seed)} % 80);
            cyc(2);
            chk(fast_rate, exp_fast(gas, 16'h0004), "fast flag");
        end
        gas = 16'h0028;
        wait_rpt();
        wait_rpt();
        chk(rpt_gap, FAST, "fast gap");
        gas = 16'h0000;
        // short hold refused, full hold opens menu
        keys.page = 1'b1;
        cyc(HOLD - 2);
        keys = '0;
        cyc(2);
        chk(menu_screen, ST_NORMAL, "short hold");
        enter();
        chk(menu_screen, ST_TIMERS, "menu open");
        chk(alarm_inhibit, 1'b1, "inhibit in menu");
        press(2);
        press(2);
        chk(menu_screen, ST_BG_LO, "bg screen");
        repeat (8) press(1);
        chk(cfg.bg, 16'h000A, "bg max");
        repeat (12) press(0);
        chk(cfg.bg, 16'h0001, "bg min");
        press(2);
        chk(menu_screen, ST_R1_MODE, "r1 mode screen");
        press(1);
        chk(cfg.latch, 2'h0, "latch pending");
        press(2);
        chk(cfg.latch, 2'h1, "latch commit");
        press(0);
        press(0);
        press(2);
        chk({menu_screen, cfg.latch}, {ST_R1_FS, 2'h1}, "r2 kept auto");
        press(1);
        chk(cfg.failsafe, 2'h1, "failsafe on");
        gas = 16'h0258;
        press(2);
        press(2);
        chk(menu_screen, ST_NORMAL, "menu exit");
        // alarm held off after exit, then both relays trip
        cyc(INH - 4);
        chk({alarm_inhibit, relay_alarm}, 3'h4, "inhibited");
        cyc(6);
        chk({alarm_inhibit, relay_alarm}, 3'h3, "alarm on");
        chk(relay_drive, 2'h2, "drive polarity");
        gas = 16'h01C3;
        cyc(3);
        chk(relay_alarm, 2'h3, "hysteresis hold");
        gas = 16'h01C2;
        cyc(3);
        chk(relay_alarm, 2'h1, "auto release");
        gas = 16'h01F4;
        pulse(relay_reset_key);
        chk(relay_alarm, 2'h3, "reset at setpoint");
        gas = 16'h01F3;
        pulse(relay_reset_key);
        cyc(1);
        chk({relay_alarm, relay_drive}, 4'hB, "manual reset");
        unit_on = 1'b0;
        cyc(2);
        chk(relay_drive, 2'h0, "unit off");
        unit_on = 1'b1;
        gas = 16'h0000;
        // day, zero, calibration and radio counters
        repeat (3) pulse(day_tick);
        chk({info.days_zero, info.days_cal}, {16'h0003, 16'h0003}, "days");
        pulse(zero_done);
        pulse(span_timed_done);
        chk({info.days_zero, info.days_cal, info.cal_num}, 48'h1, "timed span");
        pulse(day_tick);
        span_keyed_active = 1'b1;
        pulse(span_keyed_done);
        chk({info.days_cal, info.cal_num}, 32'h0001_0001, "keyed no press");
        press(1);
        pulse(span_keyed_done);
        span_keyed_active = 1'b0;
        chk({info.days_cal, info.cal_num}, 32'h0000_0002, "keyed press");
        n = {$random(seed)} % 6 + 1;
        repeat (n) pulse(radio_missed);
        chk(info.radio_miss, n, "radio miss");
        chk(info.mfg_date, 32'h0000_0A5A, "date");
        chk(info.serial, 32'h0000_5A5A, "serial");
        // oxygen thresholds, then idle timeout back to normal
        o2_sensor = 1'b1;
        enter();
        press(2);
        press(2);
        press(1);
        press(2);
        chk({menu_screen, cfg.o2_lo}, {ST_BG_HI, 16'h00BF}, "o2 low");
        press(0);
        chk(cfg.o2_hi, 16'h00DB, "o2 high");
        cyc(IDLE - 4);
        chk(menu_screen, ST_BG_HI, "idle wait");
        cyc(6);
        chk(menu_screen, ST_NORMAL, "idle exit");
        chk(fast_rate, 1'b1, "o2 low fast");
        gas = 16'h00D1;
        cyc(2);
        chk(fast_rate, 1'b0, "o2 normal slow");
        stop_test();
    end
endmodule // tb_top
